/* core/led_pwm_unit.sv */
// Overview of operation
// - one 8-bit counter, sixteen compared outputs
// - even channels left-aligned, odd right-aligned
// - shadow duty loads at cycle start while running, every mclk while stopped
// - grouped mode loads all only after sync while running; stopped, it loads every mclk
// - sync write applies duties next cycle
// - hardware clears sync after the transfer
// - trigger flag sticky until software clears
// - zero flag sticky until software clears
// - clock scale field divides counter tick
// - trigger pointer selects trigger event count
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module led_pwm_unit
  import led_pwm_pkg::*;
#(
  parameter int ADDR_W = 20
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [CHANNELS-1:0] pwm_out,
  output logic irq
);
  if (ADDR_W < IDX_W + 2)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  logic [7:0] config_reg;
  logic [7:0] clock_scale_reg;
  logic [7:0] trigger_pointer_reg;
  logic sync_reg;
  logic sync_next;
  logic trigger_flag_reg;
  logic trigger_flag_next;
  logic zero_flag_reg;
  logic zero_flag_next;
  logic running_reg;
  logic running_next;
  logic [DUTY_W-1:0] shadow_reg [CHANNELS];
  logic [DUTY_W-1:0] active_reg [CHANNELS];
  logic [CHANNELS-1:0] pwm_out_reg;
  logic [CHANNELS-1:0] pwm_out_next;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // apb decode; one wait state, commit on the pready edge
  wire [IDX_W-1:0] idx = paddr[IDX_W+1:2];
  // shift rather than part-select: no upper bits exist at the minimum width
  wire aligned = (paddr[1:0] == 2'b00) && ((paddr >> (IDX_W + 2)) == '0);
  wire hit_config = aligned && (idx == CONFIG_IDX);
  wire hit_scale = aligned && (idx == CLOCK_SCALE_IDX);
  wire hit_int = aligned && (idx == SYNC_FLAGS_IDX);
  wire hit_trig = aligned && (idx == TRIGGER_PTR_IDX);
  wire hit_duty = aligned && (idx[IDX_W-1:4] == DUTY_BASE_IDX[IDX_W-1:4]);
  wire [3:0] duty_sel = idx[3:0];
  wire mapped = hit_config || hit_scale || hit_int || hit_trig || hit_duty;
  wire access_start = psel && penable && !pready_reg;
  wire commit = psel && penable && pready_reg;
  wire wr_commit = commit && pwrite && mapped;
  wire wr_config = wr_commit && hit_config;
  wire wr_scale = wr_commit && hit_scale;
  wire wr_int = wr_commit && hit_int;
  wire wr_trig = wr_commit && hit_trig;
  wire wr_duty = wr_commit && hit_duty;

  wire [7:0] int_view = {sync_reg, 5'b00000, trigger_flag_reg, zero_flag_reg};
  wire [7:0] duty_view = shadow_reg[duty_sel];
  wire [7:0] read_mux = hit_config ? config_reg :
                        hit_scale ? clock_scale_reg :
                        hit_int ? int_view :
                        hit_trig ? trigger_pointer_reg :
                        hit_duty ? duty_view : 8'h00;
  wire [7:0] config_wmask = 8'hD3;

  // time base
  logic tick;
  logic wrap;
  logic [7:0] count;

  led_pwm_timebase u_timebase (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(running_reg),
    .scale(clock_scale_reg),
    .tick(tick),
    .wrap(wrap),
    .count(count)
  );

  wire enable = config_reg[CFG_ENABLE_BIT];
  wire grouped = config_reg[CFG_GROUPED_BIT];
  wire [7:0] count_inc = count + 8'h01;
  wire zero_event = running_reg && wrap;
  wire trigger_event = running_reg && tick && (count_inc == trigger_pointer_reg);
  // while stopped duty writes pass straight through so the first cycle is right
  wire cycle_load = running_reg ? (wrap && (!grouped || sync_reg)) : 1'b1;

  // the cycle always completes before stopping, avoiding a truncated pulse
  assign running_next = running_reg ? !(wrap && !enable) : enable;

  // set by software, cleared once the load happens; a new write wins
  assign sync_next = (wr_int && pwdata[INT_SYNC_BIT]) ? 1'b1 :
                     (cycle_load ? 1'b0 : sync_reg);
  // software clears a flag by writing zero; a same-cycle event wins
  assign trigger_flag_next = trigger_event ? 1'b1 :
                             ((wr_int && !pwdata[INT_TRIG_BIT]) ? 1'b0 : trigger_flag_reg);
  assign zero_flag_next = zero_event ? 1'b1 :
                          ((wr_int && !pwdata[INT_ZERO_BIT]) ? 1'b0 : zero_flag_reg);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      wire [8:0] right_sum = {1'b0, count} + {1'b0, active_reg[ch]};
      wire right_on = right_sum[8];
      wire left_on = count < active_reg[ch];
      if (ch % 2 == 0)
      begin : g_left
        assign pwm_out_next[ch] = running_reg && left_on;
      end
      else
      begin : g_right
        assign pwm_out_next[ch] = running_reg && right_on;
      end

      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          shadow_reg[ch] <= DUTY_RESET;
          active_reg[ch] <= DUTY_RESET;
        end
        else
        begin
          if (wr_duty && duty_sel == 4'(ch))
            shadow_reg[ch] <= pwdata[7:0];
          if (cycle_load)
            active_reg[ch] <= shadow_reg[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      config_reg <= CONFIG_RESET;
      clock_scale_reg <= CLOCK_SCALE_RESET;
      trigger_pointer_reg <= TRIGGER_PTR_RESET;
    end
    else
    begin
      if (wr_config)
        config_reg <= pwdata[7:0] & config_wmask;
      if (wr_scale)
        clock_scale_reg <= pwdata[7:0];
      if (wr_trig)
        trigger_pointer_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync_reg <= SYNC_FLAGS_RESET[INT_SYNC_BIT];
      trigger_flag_reg <= SYNC_FLAGS_RESET[INT_TRIG_BIT];
      zero_flag_reg <= SYNC_FLAGS_RESET[INT_ZERO_BIT];
      running_reg <= 1'b0;
      pwm_out_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= sync_next;
      trigger_flag_reg <= trigger_flag_next;
      zero_flag_reg <= zero_flag_next;
      running_reg <= running_next;
      pwm_out_reg <= pwm_out_next;
      irq_reg <= (trigger_flag_reg && config_reg[CFG_TRIG_IE_BIT]) ||
                 (zero_flag_reg && config_reg[CFG_ZERO_IE_BIT]);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access_start;
      if (access_start)
      begin
        prdata_reg <= {24'h000000, read_mux};
        pslverr_reg <= !mapped;
      end
      else if (commit)
      begin
        prdata_reg <= 32'h00000000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pwm_out = pwm_out_reg;
  assign irq = irq_reg;

  a_left_even_out: assert property (@(posedge mclk) disable iff (sys_rst)
    running_reg && $past(running_reg) |-> pwm_out_reg[0] == ($past(count) < $past(active_reg[0])))
    else $error("channel 0 not left aligned");

  a_right_odd_out: assert property (@(posedge mclk) disable iff (sys_rst)
    running_reg && $past(running_reg) && $past(active_reg[1]) != 8'h00 && $past(count) == 8'hFF
      |-> pwm_out_reg[1])
    else $error("channel 1 not high at end of period");

  a_right_zero_duty: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(active_reg[1]) == 8'h00 |-> !pwm_out_reg[1])
    else $error("zero duty produced a pulse");

  a_active_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    running_reg && !wrap |=> $stable(active_reg[2]))
    else $error("active duty changed mid cycle");

  a_grouped_wait: assert property (@(posedge mclk) disable iff (sys_rst)
    running_reg && grouped && !sync_reg |=> $stable(active_reg[3]))
    else $error("grouped mode loaded without sync");

  a_sync_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    running_reg && wrap && sync_reg && !wr_int |=> !sync_reg)
    else $error("sync not cleared after load");

  a_trig_sets: assert property (@(posedge mclk) disable iff (sys_rst)
    trigger_event |=> trigger_flag_reg)
    else $error("trigger flag not set");

  a_zero_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    zero_flag_reg && !wr_int |=> zero_flag_reg)
    else $error("zero flag dropped without software");

  a_irq_cause: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_reg |-> $past(trigger_flag_reg && config_reg[CFG_TRIG_IE_BIT]) ||
                $past(zero_flag_reg && config_reg[CFG_ZERO_IE_BIT]))
    else $error("interrupt without enabled flag");

  a_idle_low: assert property (@(posedge mclk) disable iff (sys_rst)
    !running_reg && !$past(running_reg) |-> pwm_out_reg == '0)
    else $error("outputs not low while stopped");

  a_stop_at_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(running_reg) |-> $past(wrap))
    else $error("stopped before cycle end");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && clock_scale_reg == 8'h01 ##1 running_reg && clock_scale_reg == 8'h01 |-> !tick)
    else $error("tick spacing wrong for scale 1");

  a_apb_ready: assert property (@(posedge mclk) disable iff (sys_rst)
    access_start |=> pready_reg ##1 !pready_reg)
    else $error("pready not a one cycle answer");
endmodule : led_pwm_unit

/* core/led_pwm_pkg.sv */
package led_pwm_pkg;
  localparam int CHANNELS = 16;
  localparam int DUTY_W = 8;
  localparam int IDX_W = 18;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CONFIG_IDX = 18'h0A04C;
  localparam logic [IDX_W-1:0] CLOCK_SCALE_IDX = 18'h0A04D;
  localparam logic [IDX_W-1:0] SYNC_FLAGS_IDX = 18'h0A04E;
  localparam logic [IDX_W-1:0] TRIGGER_PTR_IDX = 18'h0A04F;
  localparam logic [IDX_W-1:0] DUTY_BASE_IDX = 18'h0A0A0;
  // led_pwm_config fields
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_MODE_BIT = 6;
  localparam int CFG_GROUPED_BIT = 4;
  localparam int CFG_TRIG_IE_BIT = 1;
  localparam int CFG_ZERO_IE_BIT = 0;
  // led_pwm_sync_and_flags fields
  localparam int INT_SYNC_BIT = 7;
  localparam int INT_TRIG_BIT = 1;
  localparam int INT_ZERO_BIT = 0;
  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SCALE_RESET = 8'h00;
  localparam logic [7:0] SYNC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_PTR_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
endpackage : led_pwm_pkg

/* core/led_pwm_timebase.sv */
`timescale 1ns/1ps
module led_pwm_timebase
  import led_pwm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [7:0] scale,
  output logic tick,
  output logic wrap,
  output logic [7:0] count
);
  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;

  // division by scale+1; scale 0 advances every mclk
  assign tick = run && (pre_reg >= scale);
  assign wrap = tick && (count_reg == COUNT_TOP);
  assign pre_next = (!run || tick) ? 8'h00 : pre_reg + 8'h01;
  assign count_next = !run ? 8'h00 : (tick ? count_reg + 8'h01 : count_reg);
  assign count = count_reg;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pre_reg <= 8'h00;
      count_reg <= 8'h00;
    end
    else
    begin
      pre_reg <= pre_next;
      count_reg <= count_next;
    end
  end
endmodule : led_pwm_timebase

/* verif/led_array_model.sv */
`timescale 1ns/1ps
module led_array_model
(
  input wire logic mclk,
  input wire logic clear,
  input wire logic [15:0] pwm_in,
  output int unsigned lit [16]
);
  // lit time per channel over a window; an led knows no period or phase
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      lit[i] <= clear ? 0 : lit[i] + pwm_in[i];
    end
  end
endmodule : led_array_model

/* verif/led_pwm_sixteen_channel_tb.sv */
`timescale 1ns/1ps
module led_pwm_sixteen_channel_tb;
  import led_pwm_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, clear, pready, pslverr, irq, rerr;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] pwm_out;
  int unsigned lit [16];
  int mismatches, num_checks;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
  led_pwm_unit #(.ADDR_W(20)) uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
  led_array_model leds (.mclk(mclk), .clear(clear), .pwm_in(pwm_out), .lit(lit));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task complete_run;
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  function automatic logic [19:0] ba(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  // one idle cycle before each setup keeps psel from being assigned twice
  task apb(input logic wr, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'b1)
    begin
      `CHK(pready, 1'b1)
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task poll(input logic [7:0] mask, input logic [7:0] want);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ba(SYNC_FLAGS_IDX), 8'h00);
      n++;
    end
    while ((rdat[7:0] & mask) !== want && n < 300);
    if ((rdat[7:0] & mask) !== want)
    begin
      `CHK(rdat[7:0] & mask, want)
      complete_run();
    end
  endtask : poll

  // counts lit mclk edges over exactly n edges
  task meas(input int n);
    @(posedge mclk);
    clear <= 1'b1;
    @(posedge mclk);
    clear <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : meas

  task t_regs;
    logic [IDX_W-1:0] idx [5];
    idx = '{CONFIG_IDX, CLOCK_SCALE_IDX, SYNC_FLAGS_IDX, TRIGGER_PTR_IDX, DUTY_BASE_IDX};
    foreach (idx[i])
    begin
      apb(1'b0, ba(idx[i]), 8'h00);
      `CHK(rdat, 32'h00000000)
      `CHK(rerr, 1'b0)
    end
    apb(1'b1, ba(CLOCK_SCALE_IDX), 8'hA5);
    apb(1'b1, ba(TRIGGER_PTR_IDX), 8'h5A);
    apb(1'b1, ba(CONFIG_IDX), 8'h7F);
    apb(1'b0, ba(CLOCK_SCALE_IDX), 8'h00);
    `CHK(rdat, 32'h000000A5)
    apb(1'b0, ba(TRIGGER_PTR_IDX), 8'h00);
    `CHK(rdat, 32'h0000005A)
    apb(1'b0, ba(CONFIG_IDX), 8'h00);
    `CHK(rdat, 32'h00000053)
    apb(1'b1, ba(18'h0A050), 8'hFF);
    `CHK(rerr, 1'b1)
    apb(1'b0, ba(CONFIG_IDX) | 20'h00002, 8'h00);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h00000000)
  endtask : t_regs

  task t_run;
    apb(1'b1, ba(DUTY_BASE_IDX), 8'h40);
    apb(1'b1, ba(DUTY_BASE_IDX + 18'h00001), 8'h40);
    apb(1'b1, ba(CLOCK_SCALE_IDX), 8'h01);
    apb(1'b1, ba(TRIGGER_PTR_IDX), 8'h10);
    apb(1'b1, ba(CONFIG_IDX), 8'h81);
    repeat (8) @(posedge mclk);
    meas(512);
    `CHK(lit[0], 128)
    `CHK(lit[1], 128)
    `CHK(lit[2], 0)
  endtask : t_run

  task t_flags;
    time t0;
    apb(1'b1, ba(SYNC_FLAGS_IDX), 8'h00);
    poll(8'h01, 8'h01);
    // this clear lands just after the wrap, long before the trigger count
    apb(1'b1, ba(SYNC_FLAGS_IDX), 8'h00);
    apb(1'b0, ba(SYNC_FLAGS_IDX), 8'h00);
    `CHK(rdat[7:0], 8'h00)
    poll(8'h02, 8'h02);
    t0 = $time;
    `CHK(rdat[7:0], 8'h02)
    poll(8'h01, 8'h01);
    `CHK(rdat[7:0], 8'h03)
    // trigger at count 16 to wrap is 240 ticks of two mclk, give or take the poll cadence
    `CHK((($time - t0) / 40) inside {[476:484]}, 1'b1)
    `CHK(irq, 1'b1)
    apb(1'b1, ba(SYNC_FLAGS_IDX), 8'h00);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
  endtask : t_flags

  task t_group;
    apb(1'b1, ba(CONFIG_IDX), 8'h93);
    apb(1'b1, ba(DUTY_BASE_IDX), 8'h20);
    repeat (600) @(posedge mclk);
    meas(512);
    `CHK(lit[0], 128)
    apb(1'b1, ba(SYNC_FLAGS_IDX), 8'h00);
    poll(8'h01, 8'h01);
    apb(1'b1, ba(SYNC_FLAGS_IDX), 8'h80);
    apb(1'b0, ba(SYNC_FLAGS_IDX), 8'h00);
    `CHK(rdat[7], 1'b1)
    poll(8'h80, 8'h00);
    meas(512);
    `CHK(lit[0], 64)
  endtask : t_group

  task t_stop;
    apb(1'b1, ba(CONFIG_IDX), 8'h00);
    // a few ticks after the wrap: left channel high, right one still low
    `CHK(pwm_out[0], 1'b1)
    `CHK(pwm_out[1], 1'b0)
    repeat (600) @(posedge mclk);
    meas(512);
    `CHK(lit[1], 0)
    `CHK(pwm_out, 16'h0000)
  endtask : t_stop

  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h00000;
    pwdata = 32'h00000000;
    clear = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_run();
    t_flags();
    t_group();
    t_stop();
    complete_run();
  end
endmodule : led_pwm_sixteen_channel_tb
